// File: logic/spc_map.svh
// Offsets, field positions, reset values and counts of the socket power block
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH
`define SPC_PRESENT_STATE_OFS 12'h008
`define SPC_MODE_BIT          2
`define SPC_MODE_RST          1'b0
`define SPC_SYNC_RST          7'h0c
`define SPC_PS_CD1            0
`define SPC_PS_CD2            1
`define SPC_PS_CARD_IN        2
`define SPC_PS_CARD16         3
`define SPC_PS_CARD32         4
`define SPC_PS_V50            5
`define SPC_PS_V33            6
`define SPC_PS_VXX            7
`define SPC_PS_VYY            8
`define SPC_PS_RSVD           9
`define SPC_PS_VCC_LO         10
`define SPC_PS_VPP_LO         12
`define SPC_PS_MODE           14
`define SPC_PS_BUSY           15
`define SPC_PS_NACK           16
`define SPC_PS_RST            32'h0000_0000
`define SPC_CMD_BITS          8
`define SPC_SMB_SLOTS         5'h12
`define SPC_SMB_ACK0          5'h08
`define SPC_SMB_ACK1          5'h11
`define SPC_STRAP_WAIT        2'h2
`define SPC_PIECES_8BIT       2'h3
`define SPC_PIECES_16BIT      2'h1
`endif

// File: logic/spc_pkg.sv
// Types shared by the socket power block
`default_nettype none
package spc_pkg;
  typedef enum logic [2:0] {LK_IDLE, LK_START, LK_SHIFT, LK_LATCH, LK_STOP} spc_link_st_t;
  typedef enum logic [1:0] {TM_IDLE, TM_SETUP, TM_ACTIVE, TM_RECOV} spc_tmr_st_t;
endpackage : spc_pkg
`default_nettype wire

// File: logic/spc_cmd_if.sv
// Carrier between the socket block and its command strobe timer
`default_nettype none
interface spc_cmd_if;
  logic             req;
  logic             set_sel;
  logic             is_io;
  logic             wide;
  logic [1:0][7:0]  t_setup;
  logic [1:0][7:0]  t_active;
  logic [1:0][7:0]  t_recov;
  logic             busy;
  logic             done;
  logic             mem_strobe_n;
  logic             io_strobe_n;
  logic [1:0]       cycle_idx;
  modport ctl (output req, set_sel, is_io, wide, t_setup, t_active, t_recov,
               input busy, done, mem_strobe_n, io_strobe_n, cycle_idx);
  modport tmr (input req, set_sel, is_io, wide, t_setup, t_active, t_recov,
               output busy, done, mem_strobe_n, io_strobe_n, cycle_idx);
endinterface : spc_cmd_if
`default_nettype wire

// File: logic/spc_cmd_timer.sv
// Three-phase card command strobe timer with bus sizing
`include "spc_map.svh"
`default_nettype none
module spc_cmd_timer (
  input  wire logic  clk,
  input  wire logic  resetn,
  spc_cmd_if.tmr     bus
);
  spc_pkg::spc_tmr_st_t st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [1:0] piece_r, piece_nxt;
  logic [1:0] last_r, last_nxt;
  logic       sel_r, sel_nxt;
  logic       io_r, io_nxt;
  logic       mem_n_r, mem_n_nxt;
  logic       io_n_r, io_n_nxt;
  logic       done_r, done_nxt;
  logic       busy_r, busy_nxt;

  // ****************************************
  // Phase sequencer
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    piece_nxt = piece_r;
    last_nxt = last_r;
    sel_nxt = sel_r;
    io_nxt = io_r;
    mem_n_nxt = 1'b1;
    io_n_nxt = 1'b1;
    done_nxt = 1'b0;
    unique case (st_r)
      spc_pkg::TM_IDLE: begin
        if (bus.req) begin
          sel_nxt = bus.set_sel;
          io_nxt = bus.is_io;
          last_nxt = bus.wide ? `SPC_PIECES_16BIT : `SPC_PIECES_8BIT;
          piece_nxt = 2'h0;
          cnt_nxt = bus.t_setup[bus.set_sel];
          st_nxt = spc_pkg::TM_SETUP;
        end
      end
      spc_pkg::TM_SETUP: begin
        if (cnt_r == 8'h00) begin
          cnt_nxt = bus.t_active[sel_r];
          mem_n_nxt = io_r;
          io_n_nxt = !io_r;
          st_nxt = spc_pkg::TM_ACTIVE;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      spc_pkg::TM_ACTIVE: begin
        mem_n_nxt = io_r;
        io_n_nxt = !io_r;
        if (cnt_r == 8'h00) begin
          mem_n_nxt = 1'b1;
          io_n_nxt = 1'b1;
          cnt_nxt = bus.t_recov[sel_r];
          st_nxt = spc_pkg::TM_RECOV;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      spc_pkg::TM_RECOV: begin
        if (cnt_r != 8'h00) begin
          cnt_nxt = cnt_r - 8'h01;
        end else if (piece_r == last_r) begin
          done_nxt = 1'b1;
          st_nxt = spc_pkg::TM_IDLE;
        end else begin
          piece_nxt = piece_r + 2'h1;
          cnt_nxt = bus.t_setup[sel_r];
          st_nxt = spc_pkg::TM_SETUP;
        end
      end
    endcase
    busy_nxt = (st_nxt != spc_pkg::TM_IDLE);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= spc_pkg::TM_IDLE;
      cnt_r <= 8'h00;
      piece_r <= 2'h0;
      last_r <= 2'h0;
      sel_r <= 1'b0;
      io_r <= 1'b0;
      mem_n_r <= 1'b1;
      io_n_r <= 1'b1;
      done_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      piece_r <= piece_nxt;
      last_r <= last_nxt;
      sel_r <= sel_nxt;
      io_r <= io_nxt;
      mem_n_r <= mem_n_nxt;
      io_n_r <= io_n_nxt;
      done_r <= done_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign bus.mem_strobe_n = mem_n_r;
  assign bus.io_strobe_n = io_n_r;
  assign bus.cycle_idx = piece_r;
  assign bus.done = done_r;
  assign bus.busy = busy_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_strobe_after_setup: assert property ((st_r == spc_pkg::TM_SETUP && cnt_r == 8'h00)
    |=> (mem_n_r != io_n_r) && st_r == spc_pkg::TM_ACTIVE) else $error("strobe late");
  a_set_taken: assert property ((st_r == spc_pkg::TM_IDLE && bus.req)
    |=> sel_r == $past(bus.set_sel) && cnt_r == $past(bus.t_setup[bus.set_sel]))
    else $error("timer set not taken");
  a_size_pieces: assert property ((st_r == spc_pkg::TM_IDLE && bus.req)
    |=> last_r == ($past(bus.wide) ? 2'h1 : 2'h3)) else $error("bad split");
  a_no_strobe_idle: assert property (st_r == spc_pkg::TM_IDLE |-> mem_n_r && io_n_r)
    else $error("strobe while idle");
  c_word_done: cover property (done_r && last_r == 2'h3);
endmodule : spc_cmd_timer
`default_nettype wire

// File: logic/spc_socket_power.sv
// Socket power switch link, card sensing and command timing for one socket
`include "spc_map.svh"
`default_nettype none
module spc_socket_power #(
  parameter int         CMD_BITS = `SPC_CMD_BITS,
  // Arbitrary switch address, set to match the board
  parameter logic [6:0] SMB_ADDR = 7'h2a
) (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        SCLK,
  input  wire logic        PIN_LATCH_I,
  output logic             PIN_LATCH_O,
  output logic             PIN_LATCH_OE,
  input  wire logic        PIN_DATA_I,
  output logic             PIN_DATA_O,
  output logic             PIN_DATA_OE,
  input  wire logic        CARD_DETECT_ONE_N,
  input  wire logic        CARD_DETECT_TWO_N,
  input  wire logic        VOLT_SENSE_ONE,
  input  wire logic        VOLT_SENSE_TWO,
  input  wire logic        MODE_WR,
  input  wire logic        MODE_WR_BIT,
  input  wire logic        PWR_REQ,
  input  wire logic [1:0]  PWR_VCC,
  input  wire logic [1:0]  PWR_VPP,
  input  wire logic        DETECT_IRQ_EN,
  input  wire logic        REMOVAL_IRQ_EN,
  output logic             DETECT_IRQ,
  output logic             REMOVAL_IRQ,
  output logic [31:0]      PRESENT_STATE,
  input  wire logic        ACC_REQ,
  input  wire logic        ACC_SET_SEL,
  input  wire logic        ACC_IS_IO,
  input  wire logic        ACC_CARD16,
  input  wire logic        ATA_MODE,
  input  wire logic [7:0]  T0_SETUP,
  input  wire logic [7:0]  T0_ACTIVE,
  input  wire logic [7:0]  T0_RECOV,
  input  wire logic [7:0]  T1_SETUP,
  input  wire logic [7:0]  T1_ACTIVE,
  input  wire logic [7:0]  T1_RECOV,
  output logic             ACC_BUSY,
  output logic             ACC_DONE,
  output logic             MEM_STROBE_N,
  output logic             IO_STROBE_N,
  output logic [1:0]       CARD_CYCLE_IDX
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [6:0] meta_r;
  logic [6:0] sync_r;
  logic       sclk_d_r;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      // Detects start released, so no false removal or event follows reset
      meta_r <= `SPC_SYNC_RST;
      sync_r <= `SPC_SYNC_RST;
      sclk_d_r <= 1'b0;
    end else begin
      meta_r <= {SCLK, PIN_LATCH_I, PIN_DATA_I, CARD_DETECT_TWO_N, CARD_DETECT_ONE_N,
                 VOLT_SENSE_TWO, VOLT_SENSE_ONE};
      sync_r <= meta_r;
      sclk_d_r <= sync_r[6];
    end
  end
  logic       sclk_rise, sclk_fall, tick;
  logic [1:0] cd_n, vs;
  assign sclk_rise = sync_r[6] && !sclk_d_r;
  assign sclk_fall = !sync_r[6] && sclk_d_r;
  // SMBus steps after the start are paced by either slow clock edge
  assign tick = sclk_rise || sclk_fall;
  assign cd_n = sync_r[3:2];
  assign vs = sync_r[1:0];

  // ****************************************
  // Mode strap and override
  // ****************************************
  logic [1:0] strap_cnt_r, strap_cnt_nxt;
  logic       strap_done_r, strap_done_nxt;
  logic       mode_r, mode_nxt;
  always_comb begin
    strap_cnt_nxt = strap_cnt_r;
    strap_done_nxt = strap_done_r;
    mode_nxt = mode_r;
    // strap caught once the synchroniser has filled
    if (!strap_done_r) begin
      if (strap_cnt_r == `SPC_STRAP_WAIT) begin
        mode_nxt = sync_r[5];
        strap_done_nxt = 1'b1;
      end else begin
        strap_cnt_nxt = strap_cnt_r + 2'h1;
      end
    end
    // bit 0 selects three-wire, 1 selects SMBus
    if (MODE_WR) begin
      mode_nxt = MODE_WR_BIT;
    end
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      strap_cnt_r <= 2'h0;
      strap_done_r <= 1'b0;
      mode_r <= `SPC_MODE_RST;
    end else begin
      strap_cnt_r <= strap_cnt_nxt;
      strap_done_r <= strap_done_nxt;
      mode_r <= mode_nxt;
    end
  end

  // ****************************************
  // Card sensing and socket power
  // ****************************************
  logic        card16, card32, card_in, removal, det_chg;
  logic [1:0]  cd_prev_r;
  logic        card_in_r, card_in_nxt;
  logic [1:0]  vcc_r, vcc_nxt, vpp_r, vpp_nxt;
  logic        det_irq_r, det_irq_nxt, rem_irq_r, rem_irq_nxt;
  logic [31:0] ps_r, ps_nxt;
  logic        link_busy, nack_r;
  spc_pkg::spc_link_st_t st_r;
  // both detects low is a 16-bit card, one low a cross-strapped 32-bit card
  // low-voltage key assumed, so 32-bit cards are accepted
  assign card16 = (cd_n == 2'b00);
  assign card32 = (cd_n == 2'b01) || (cd_n == 2'b10);
  assign card_in = card16 || card32;
  assign removal = card_in_r && !card_in;
  assign det_chg = (cd_n != cd_prev_r);
  assign link_busy = (st_r != spc_pkg::LK_IDLE);
  always_comb begin
    card_in_nxt = card_in;
    vcc_nxt = vcc_r;
    vpp_nxt = vpp_r;
    if (!card_in) begin
      vcc_nxt = 2'h0;
      vpp_nxt = 2'h0;
    end else if (PWR_REQ) begin
      vcc_nxt = PWR_VCC;
      vpp_nxt = PWR_VPP;
    end
    det_irq_nxt = det_chg && DETECT_IRQ_EN;
    rem_irq_nxt = removal && REMOVAL_IRQ_EN;
    ps_nxt = `SPC_PS_RST;
    ps_nxt[`SPC_PS_CD1] = cd_n[0];
    ps_nxt[`SPC_PS_CD2] = cd_n[1];
    ps_nxt[`SPC_PS_CARD_IN] = card_in;
    ps_nxt[`SPC_PS_CARD16] = card16;
    ps_nxt[`SPC_PS_CARD32] = card32;
    ps_nxt[`SPC_PS_V50] = card16 && vs == 2'b11;
    ps_nxt[`SPC_PS_V33] = (card16 && vs == 2'b00) || card32;
    ps_nxt[`SPC_PS_VXX] = card16 && vs == 2'b01;
    ps_nxt[`SPC_PS_VYY] = card32 && vs == 2'b10;
    ps_nxt[`SPC_PS_RSVD] = card16 && vs == 2'b10;
    ps_nxt[`SPC_PS_VCC_LO +: 2] = vcc_nxt;
    ps_nxt[`SPC_PS_VPP_LO +: 2] = vpp_nxt;
    ps_nxt[`SPC_PS_MODE] = mode_r;
    ps_nxt[`SPC_PS_BUSY] = link_busy;
    ps_nxt[`SPC_PS_NACK] = nack_r;
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cd_prev_r <= 2'b11;
      card_in_r <= 1'b0;
      vcc_r <= 2'h0;
      vpp_r <= 2'h0;
      det_irq_r <= 1'b0;
      rem_irq_r <= 1'b0;
      ps_r <= `SPC_PS_RST;
    end else begin
      cd_prev_r <= cd_n;
      card_in_r <= card_in_nxt;
      vcc_r <= vcc_nxt;
      vpp_r <= vpp_nxt;
      det_irq_r <= det_irq_nxt;
      rem_irq_r <= rem_irq_nxt;
      ps_r <= ps_nxt;
    end
  end

  // ****************************************
  // Power switch link
  // ****************************************
  logic [17:0] sh_r, sh_nxt;
  logic [4:0]  cnt_r, cnt_nxt;
  logic        ph_r, ph_nxt, pend_r, pend_nxt, nack_nxt;
  logic [7:0]  pcmd_r, pcmd_nxt;
  logic        lo_r, lo_nxt, loe_r, loe_nxt, do_r, do_nxt, doe_r, doe_nxt;
  logic        ack_slot;
  spc_pkg::spc_link_st_t st_nxt;
  assign ack_slot = (cnt_r == `SPC_SMB_ACK0) || (cnt_r == `SPC_SMB_ACK1);
  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    ph_nxt = ph_r;
    pend_nxt = pend_r;
    pcmd_nxt = pcmd_r;
    nack_nxt = nack_r;
    lo_nxt = lo_r;
    loe_nxt = loe_r;
    do_nxt = do_r;
    doe_nxt = doe_r;
    if (!strap_done_r) begin
      // Latch pin is the strap until it has been caught
      loe_nxt = 1'b0;
      doe_nxt = 1'b0;
    end else begin
      unique case (st_r)
        spc_pkg::LK_IDLE: begin
          lo_nxt = 1'b0;
          do_nxt = 1'b0;
          loe_nxt = !mode_r;
          doe_nxt = !mode_r;
          // start only from idle, after any latch pulse
          if (pend_r) begin
            pend_nxt = 1'b0;
            cnt_nxt = 5'h00;
            ph_nxt = 1'b0;
            if (mode_r) begin
              nack_nxt = 1'b0;
              sh_nxt = {SMB_ADDR, 1'b0, 1'b1, pcmd_r, 1'b1};
              st_nxt = spc_pkg::LK_START;
            end else begin
              sh_nxt = {pcmd_r, 10'h000};
              st_nxt = spc_pkg::LK_SHIFT;
            end
          end
        end
        spc_pkg::LK_START: begin
          // data falls while clock is released
          if (tick) begin
            doe_nxt = 1'b1;
            st_nxt = spc_pkg::LK_SHIFT;
          end
        end
        spc_pkg::LK_SHIFT: begin
          if (mode_r) begin
            // open-drain bit slots, acks left released
            if (tick && !ph_r) begin
              loe_nxt = 1'b1;
              doe_nxt = !sh_r[17] && !ack_slot;
              ph_nxt = 1'b1;
            end else if (tick) begin
              loe_nxt = 1'b0;
              ph_nxt = 1'b0;
              nack_nxt = nack_r || (ack_slot && sync_r[4]);
              sh_nxt = {sh_r[16:0], 1'b0};
              cnt_nxt = cnt_r + 5'h01;
              if (cnt_r == `SPC_SMB_SLOTS - 5'h01) begin
                st_nxt = spc_pkg::LK_STOP;
              end
            end
          // the switch shifts on rising slow clock, bits change on falling
          end else if (sclk_fall) begin
            if (cnt_r == 5'(CMD_BITS)) begin
              lo_nxt = 1'b1;
              st_nxt = spc_pkg::LK_LATCH;
            end else begin
              do_nxt = sh_r[17];
              sh_nxt = {sh_r[16:0], 1'b0};
              cnt_nxt = cnt_r + 5'h01;
            end
          end
        end
        spc_pkg::LK_LATCH: begin
          if (sclk_fall) begin
            lo_nxt = 1'b0;
            st_nxt = spc_pkg::LK_IDLE;
          end
        end
        spc_pkg::LK_STOP: begin
          if (tick && !ph_r) begin
            loe_nxt = 1'b1;
            doe_nxt = 1'b1;
            ph_nxt = 1'b1;
          end else if (tick && loe_r) begin
            loe_nxt = 1'b0;
          end else if (tick) begin
            doe_nxt = 1'b0;
            ph_nxt = 1'b0;
            st_nxt = spc_pkg::LK_IDLE;
          end
        end
        default: st_nxt = spc_pkg::LK_IDLE;
      endcase
    end
    // removal queues an all-off command, winning over a host request
    // a request during a shift waits in the queue
    if (removal) begin
      pend_nxt = 1'b1;
      pcmd_nxt = 8'h00;
    end else if (PWR_REQ && card_in) begin
      pend_nxt = 1'b1;
      pcmd_nxt = {4'h0, PWR_VCC, PWR_VPP};
    end
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_r <= spc_pkg::LK_IDLE;
      sh_r <= 18'h00000;
      cnt_r <= 5'h00;
      ph_r <= 1'b0;
      pend_r <= 1'b0;
      pcmd_r <= 8'h00;
      nack_r <= 1'b0;
      lo_r <= 1'b0;
      loe_r <= 1'b0;
      do_r <= 1'b0;
      doe_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      ph_r <= ph_nxt;
      pend_r <= pend_nxt;
      pcmd_r <= pcmd_nxt;
      nack_r <= nack_nxt;
      lo_r <= lo_nxt;
      loe_r <= loe_nxt;
      do_r <= do_nxt;
      doe_r <= doe_nxt;
    end
  end

  // ****************************************
  // Command strobe timing
  // ****************************************
  spc_cmd_if u_if ();
  // ATA drives run as 16-bit card cycles
  assign u_if.wide = ACC_CARD16 || ATA_MODE;
  assign u_if.req = ACC_REQ;
  assign u_if.set_sel = ACC_SET_SEL;
  assign u_if.is_io = ACC_IS_IO;
  assign u_if.t_setup = {T1_SETUP, T0_SETUP};
  assign u_if.t_active = {T1_ACTIVE, T0_ACTIVE};
  assign u_if.t_recov = {T1_RECOV, T0_RECOV};
  spc_cmd_timer u_tmr (
    .clk    (CLK),
    .resetn (RESETN),
    .bus    (u_if.tmr)
  );

  assign PIN_LATCH_O = lo_r;
  assign PIN_LATCH_OE = loe_r;
  assign PIN_DATA_O = do_r;
  assign PIN_DATA_OE = doe_r;
  assign DETECT_IRQ = det_irq_r;
  assign REMOVAL_IRQ = rem_irq_r;
  assign PRESENT_STATE = ps_r;
  assign ACC_BUSY = u_if.busy;
  assign ACC_DONE = u_if.done;
  assign MEM_STROBE_N = u_if.mem_strobe_n;
  assign IO_STROBE_N = u_if.io_strobe_n;
  assign CARD_CYCLE_IDX = u_if.cycle_idx;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  a_mode_override: assert property (MODE_WR |=> mode_r == $past(MODE_WR_BIT))
    else $error("mode write lost");
  a_strap_mode: assert property ($rose(strap_done_r) && !$past(MODE_WR)
    |-> mode_r == $past(sync_r[5])) else $error("strap not caught");
  a_serial_drive: assert property ((strap_done_r && !mode_r && st_r == spc_pkg::LK_IDLE)
    |=> loe_r && doe_r) else $error("three-wire pins not driven");
  a_latch_low_bits: assert property ((st_r == spc_pkg::LK_SHIFT && !mode_r) |-> !lo_r)
    else $error("latch during shift");
  a_removal_off: assert property (removal |=> pend_r && pcmd_r == 8'h00)
    else $error("removal did not queue off");
  a_removal_event: assert property (removal && REMOVAL_IRQ_EN |=> rem_irq_r)
    else $error("removal event missing");
  a_off_no_card: assert property (!card_in_r |-> vcc_r == 2'h0 && vpp_r == 2'h0)
    else $error("power without card");
  a_detect_event: assert property (det_chg && DETECT_IRQ_EN |=> det_irq_r)
    else $error("detect event missing");
  a_decode_5v: assert property ((cd_n == 2'b00 && vs == 2'b11) |=> ps_r[`SPC_PS_V50])
    else $error("5 V not decoded");
  a_queue_start: assert property ((st_r == spc_pkg::LK_IDLE && pend_r && strap_done_r)
    |=> st_r != spc_pkg::LK_IDLE) else $error("queued command stuck");
  c_serial_latch: cover property (st_r == spc_pkg::LK_LATCH && sclk_fall);
  c_smb_stop: cover property (st_r == spc_pkg::LK_STOP && mode_r);
  c_removal: cover property (removal && link_busy);
endmodule : spc_socket_power
`default_nettype wire

// File: testbench/spc_switch_model.sv
// Behavioural three-wire socket power switch
`default_nettype none
module spc_switch_model (
  input  wire logic  SCLK,
  input  wire logic  DATA,
  input  wire logic  LATCH,
  output logic [7:0] CMD,
  output var int     LOADS
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh_r = 8'h00;
  initial CMD = 8'h00;
  initial LOADS = 0;
  always @(posedge SCLK) sh_r <= {sh_r[6:0], DATA};
  always @(posedge LATCH) begin
    CMD <= sh_r;
    LOADS <= LOADS + 1;
  end
endmodule : spc_switch_model
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the socket power block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK = 0, rst_n = 0, sclk = 0, irq_en = 1;
  logic        cd1_n = 1, cd2_n = 1, vs1 = 1, vs2 = 1, m_wr = 0, m_bit = 0;
  logic        p_req = 0, a_req = 0, a_set = 0, a_io = 0, a_c16 = 0, ata = 0;
  logic [1:0]  vcc = 0, vpp = 0;
  logic [7:0]  t0s = 1, t0a = 2, t0r = 0, t1s = 0, t1a = 4, t1r = 1;
  logic        lat_o, lat_oe, dat_o, dat_oe, det, rem, done, mem_n, io_n, busy;
  logic [1:0]  idx;
  logic [31:0] ps;
  logic [7:0]  cmd;
  int          loads, n_errors = 0, comparisons = 0, d0, r0;
  int          det_c = 0, rem_c = 0, mem_c = 0, io_c = 0, done_c = 0;
  // Board pull-down on the latch pin selects the three-wire strap
  wire logic   lat_w = lat_oe ? lat_o : 1'b0;
  wire logic   dat_w = dat_oe ? dat_o : 1'b1;
  always #5 CLK = ~CLK;
  initial begin
    #3;
    forever #40 sclk = ~sclk;
  end
  // Event and done pulses are one cycle wide and strobes count once per low cycle, so tally them as they pass
  always @(posedge CLK) begin
    det_c += (det === 1'b1);
    rem_c += (rem === 1'b1);
    mem_c += (mem_n === 1'b0);
    io_c += (io_n === 1'b0);
    done_c += (done === 1'b1);
  end
  spc_socket_power spc_socket_power_inst (
    .CLK(CLK), .RESETN(rst_n), .SCLK(sclk), .PIN_LATCH_I(lat_w), .PIN_LATCH_O(lat_o),
    .PIN_LATCH_OE(lat_oe), .PIN_DATA_I(dat_w), .PIN_DATA_O(dat_o), .PIN_DATA_OE(dat_oe),
    .CARD_DETECT_ONE_N(cd1_n), .CARD_DETECT_TWO_N(cd2_n), .VOLT_SENSE_ONE(vs1),
    .VOLT_SENSE_TWO(vs2), .MODE_WR(m_wr), .MODE_WR_BIT(m_bit), .PWR_REQ(p_req),
    .PWR_VCC(vcc), .PWR_VPP(vpp), .DETECT_IRQ_EN(irq_en), .REMOVAL_IRQ_EN(irq_en),
    .DETECT_IRQ(det), .REMOVAL_IRQ(rem), .PRESENT_STATE(ps), .ACC_REQ(a_req),
    .ACC_SET_SEL(a_set), .ACC_IS_IO(a_io), .ACC_CARD16(a_c16), .ATA_MODE(ata),
    .T0_SETUP(t0s), .T0_ACTIVE(t0a), .T0_RECOV(t0r), .T1_SETUP(t1s), .T1_ACTIVE(t1a),
    .T1_RECOV(t1r), .ACC_BUSY(busy), .ACC_DONE(done), .MEM_STROBE_N(mem_n),
    .IO_STROBE_N(io_n), .CARD_CYCLE_IDX(idx));
  spc_switch_model spc_switch_model_inst (
    .SCLK(sclk), .DATA(dat_w), .LATCH(lat_w), .CMD(cmd), .LOADS(loads));
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask : cyc
  // Bounded wait on the frame count or the access-done count
  task automatic await(input bit frames, input int n);
    int k;
    k = 0;
    while ((frames ? loads : done_c) < n && k < 2000) begin
      @(posedge CLK);
      k++;
    end
    if ((frames ? loads : done_c) < n) begin
      check("wait count", n, frames ? loads : done_c);
      test_done();
    end
  endtask : await
  task automatic power(input logic [1:0] c, input logic [1:0] p);
    @(posedge CLK);
    vcc <= c;
    vpp <= p;
    p_req <= 1'b1;
    @(posedge CLK);
    p_req <= 1'b0;
  endtask : power
  task automatic access(input logic s, input logic io, input logic c16, input logic a,
                        input int lo);
    int m0, i0;
    m0 = mem_c;
    i0 = io_c;
    @(posedge CLK);
    {a_set, a_io, a_c16, ata, a_req} <= {s, io, c16, a, 1'b1};
    @(posedge CLK);
    a_req <= 1'b0;
    cyc(1);
    check("busy during access", 1, busy);
    await(1'b0, done_c + 1);
    cyc(2);
    check("mem strobe cycles", io ? 0 : lo, mem_c - m0);
    check("io strobe cycles", io ? lo : 0, io_c - i0);
    check("busy after access", 0, busy);
    check("last card cycle", (c16 || a) ? 1 : 3, idx);
  endtask : access
  initial begin
    cyc(12);
    rst_n <= 1'b1;
    cyc(10);
    check("link mode", 0, ps[14]);
    check("empty state", 32'h03, {ps[13:10], ps[2:0]});
    power(2'h1, 2'h1);
    cyc(300);
    check("frames", 0, loads);
    check("events after reset", 0, det_c + rem_c);
    $display("test empty socket done");
    for (int i = 0; i < 2; i++) begin
      d0 = det_c;
      r0 = rem_c;
      {irq_en, vs1, vs2, cd1_n} <= {i == 0, i == 0, i == 0, 1'b0};
      cyc(8);
      cd2_n <= 1'b0;
      cyc(8);
      check("card type", i ? 32'h13 : 32'h0b, ps[6:2]);
      power(2'h1, 2'h2);
      await(1'b1, i * 4 + 1);
      cyc(5);
      check("switch command", 32'h06, cmd);
      check("power fields", 32'h9, ps[13:10]);
      power(2'h2, 2'h1);
      cyc(3);
      power(2'h3, 2'h3);
      await(1'b1, i * 4 + 2);
      check("first command", 32'h09, cmd);
      await(1'b1, i * 4 + 3);
      check("queued command", 32'h0f, cmd);
      cd1_n <= 1'b1;
      cyc(8);
      cd2_n <= 1'b1;
      await(1'b1, i * 4 + 4);
      cyc(200);
      check("removal command", 32'h00, cmd);
      check("frames", i * 4 + 4, loads);
      check("power off", 0, ps[13:10]);
      check("detect events", i ? 0 : 4, det_c - d0);
      check("removal events", i ? 0 : 1, rem_c - r0);
      $display("test card %0d done", i);
    end
    access(1'b0, 1'b0, 1'b0, 1'b0, 12);
    access(1'b1, 1'b1, 1'b1, 1'b0, 10);
    access(1'b0, 1'b0, 1'b0, 1'b1, 6);
    $display("test strobes done");
    {m_bit, m_wr} <= 2'b11;
    @(posedge CLK);
    m_wr <= 1'b0;
    cyc(5);
    check("mode override", 1, ps[14]);
    $display("test mode done");
    {cd1_n, cd2_n} <= 2'b00;
    cyc(8);
    power(2'h1, 2'h1);
    cyc(20);
    check("smbus busy", 1, ps[15]);
    cyc(400);
    check("smbus released", 0, {ps[15], lat_oe, dat_oe});
    check("smbus nack", 1, ps[16]);
    check("frames", 8, loads);
    $display("test smbus done");
    test_done();
  end
endmodule : testbench
`default_nettype wire
